/* src/sfr_regs.sv */
// sfr_regs: serial-interface fault status bank behind an AHB-Lite slave
// assumes: fault events arrive as core_clk-synchronous pulses or levels from
// the interface logic; mode pins are stable when captured after reset release
//
// Overview of operation
// - 8-bit read-only fault register, resets zero, bits 7:3 read zero
// - startup flag bit 2 set on power-up error, cleared only by reset
// - chip-select fault bit 1 set by CS edge during SCLK high
// - frame fault bit 0 set by short frame of SCLK cycles
// - 8-bit error counter of Hamming/CRC errors saturates at FFh
// - error counter returns value on read then clears to zero, or to one if an error arrives in the clearing cycle
// - bits 5:4 show captured Hamming-select pin state
// - bits 3:2 show captured word-width pin state
// - bits 1:0 show captured interface-mode pin state
// - mode-pin register read-only, bits 7:6 zero, value captured from pins
// - locations 08h to 0Ah read zero and ignore writes
// - analog configuration register at 0Bh, reset 60h
// - summary fault bit in primary status, cleared by fault register read
//
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ns
module sfr_regs
   import sfr_pkg::*;
(
   input  wire logic                  core_clk,
   input  wire logic                  rst_n,
   input  wire logic                  hsel,
   input  wire logic [31:0]           haddr,
   input  wire logic [1:0]            htrans,
   input  wire logic                  hwrite,
   input  wire logic [2:0]            hsize,
   input  wire logic [31:0]           hwdata,
   input  wire logic                  hready,
   output logic [31:0]                hrdata,
   output logic                       hreadyout,
   output logic                       hresp,
   input  wire sfr_pkg::sfr_events_t  events,
   input  wire sfr_pkg::sfr_mode_pins_t mode_pins,
   output logic [7:0]                 analog_system_config,
   output logic                       irq
);
   import sfr_pkg::*;

   sfr_addr_phase_t  ap_q;
   sfr_mode_pins_t   mode_pin_capture_q;
   logic             captured_q;
   logic [2:0]       spi_fault_q;
   logic             spi_summary_q;
   logic [7:0]       ana_cfg_q;
   logic [2:0]       irq_stat_q;
   logic [2:0]       irq_mask_q;
   logic [7:0]       err_cnt;
   logic             err_sat;
   logic [31:0]      rdata_d;
   logic             take;
   logic             rd_fault;
   logic             rd_cnt;
   logic             rd_irq;
   logic             wr_ana;
   logic             wr_mask;
   logic             cnt_inc_ev;

   // address phase accepted only on a valid NONSEQ/SEQ with hready high
   assign take = hsel && hready && htrans[1];

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         ap_q <= '0;
      end else if (hready) begin
         ap_q.sel   <= take;
         ap_q.write <= hwrite;
         ap_q.idx   <= haddr[9:2];
      end
   end

   // reads take effect in the data phase, the same cycle hrdata is returned
   assign rd_fault = ap_q.sel && !ap_q.write && ap_q.idx == REG_SPI_FAULT_IDX;
   assign rd_cnt   = ap_q.sel && !ap_q.write && ap_q.idx == REG_ERR_CNT_IDX;
   assign rd_irq   = ap_q.sel && !ap_q.write && ap_q.idx == REG_IRQ_STAT_IDX;
   assign wr_ana   = ap_q.sel && ap_q.write && ap_q.idx == REG_ANA_CFG_IDX;
   assign wr_mask  = ap_q.sel && ap_q.write && ap_q.idx == REG_IRQ_MASK_IDX;

   // pins caught once, one cycle after reset release, never under reset
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         captured_q <= 1'b0;
      end else begin
         captured_q <= 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         mode_pin_capture_q <= '0;
      end else if (!captured_q) begin
         mode_pin_capture_q <= mode_pins;
      end
   end

   // startup flag ignores reads; only reset (power cycle) clears it
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         spi_fault_q[FLT_STARTUP_BIT] <= 1'b0;
      end else if (events.startup_fault) begin
         spi_fault_q[FLT_STARTUP_BIT] <= 1'b1;
      end
   end

   // set wins over read-clear, so a persisting condition stays visible
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         spi_fault_q[FLT_CS_BIT] <= 1'b0;
      end else if (events.cs_edge_sclk_high) begin
         spi_fault_q[FLT_CS_BIT] <= 1'b1;
      end else if (rd_fault) begin
         spi_fault_q[FLT_CS_BIT] <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         spi_fault_q[FLT_FRAME_BIT] <= 1'b0;
      end else if (events.frame_short) begin
         spi_fault_q[FLT_FRAME_BIT] <= 1'b1;
      end else if (rd_fault) begin
         spi_fault_q[FLT_FRAME_BIT] <= 1'b0;
      end
   end

   // summary bit: set by a startup, chip-select or frame-short event (not rx_word_error), cleared by reading the fault register
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         spi_summary_q <= 1'b0;
      end else if (events.startup_fault || events.cs_edge_sclk_high || events.frame_short) begin
         spi_summary_q <= 1'b1;
      end else if (rd_fault) begin
         spi_summary_q <= 1'b0;
      end
   end

   assign cnt_inc_ev = events.rx_word_error;

   sfr_sat_counter u_err_cnt (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .inc      (cnt_inc_ev),
      .clr      (rd_cnt),
      .count_q  (err_cnt),
      .sat_q    (err_sat)
   );

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         ana_cfg_q <= ANA_CFG_RST;
      end else if (wr_ana) begin
         ana_cfg_q <= hwdata[7:0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         irq_mask_q <= IRQ_MASK_RST;
      end else if (wr_mask) begin
         irq_mask_q <= hwdata[2:0];
      end
   end

   // sticky interrupt causes; an event in the read cycle survives the clear
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         irq_stat_q <= '0;
      end else begin
         irq_stat_q[IRQ_CS_BIT]    <= events.cs_edge_sclk_high
                                      || (irq_stat_q[IRQ_CS_BIT] && !rd_irq);
         irq_stat_q[IRQ_FRAME_BIT] <= events.frame_short
                                      || (irq_stat_q[IRQ_FRAME_BIT] && !rd_irq);
         irq_stat_q[IRQ_CNT_BIT]   <= (cnt_inc_ev && !err_sat)
                                      || (irq_stat_q[IRQ_CNT_BIT] && !rd_irq);
      end
   end

   // one cycle behind status; kept registered so the output is clean
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_stat_q & irq_mask_q);
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         analog_system_config <= ANA_CFG_RST;
      end else begin
         analog_system_config <= wr_ana ? hwdata[7:0] : ana_cfg_q;
      end
   end

   // read mux works on the address phase so hrdata is a flop in the data phase
   always_comb begin
      rdata_d = 32'h0000_0000;
      case (haddr[9:2])
         REG_PRIMARY_IDX: begin
            rdata_d[PRI_SPI_FAULT_BIT] = spi_summary_q;
         end
         REG_SPI_FAULT_IDX: begin
            rdata_d[2:0] = spi_fault_q;
         end
         REG_ERR_CNT_IDX: begin
            rdata_d[7:0] = err_cnt;
         end
         REG_MODE_PIN_IDX: begin
            rdata_d[HAM_POS+1:HAM_POS] = mode_pin_capture_q.hamming_pin_state;
            rdata_d[WID_POS+1:WID_POS] = mode_pin_capture_q.word_width_pin_state;
            rdata_d[IFM_POS+1:IFM_POS] = mode_pin_capture_q.interface_mode_pin_state;
         end
         REG_ANA_CFG_IDX: begin
            rdata_d[7:0] = ana_cfg_q;
         end
         REG_IRQ_STAT_IDX: begin
            rdata_d[2:0] = irq_stat_q;
         end
         REG_IRQ_MASK_IDX: begin
            rdata_d[2:0] = irq_mask_q;
         end
         default: begin
            rdata_d = 32'h0000_0000;
         end
      endcase
   end

   // limitation: a read-clear flag set between address and data phase misses hrdata; that read clears it unless the event persists
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         hrdata <= 32'h0000_0000;
      end else if (take && !hwrite) begin
         hrdata <= rdata_d;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end
endmodule : sfr_regs

/* src/sfr_pkg.sv */
// sfr_pkg: constants and carrier types for the serial-interface fault status bank
// assumes: one 50 MHz clock, AHB-Lite word registers at index*4
package sfr_pkg;
   localparam logic [7:0] REG_PRIMARY_IDX    = 8'h01;
   localparam logic [7:0] REG_SPI_FAULT_IDX  = 8'h05;
   localparam logic [7:0] REG_ERR_CNT_IDX    = 8'h06;
   localparam logic [7:0] REG_MODE_PIN_IDX   = 8'h07;
   localparam logic [7:0] REG_RSVD_A_IDX     = 8'h08;
   localparam logic [7:0] REG_RSVD_C_IDX     = 8'h0A;
   localparam logic [7:0] REG_ANA_CFG_IDX    = 8'h0B;
   localparam logic [7:0] REG_IRQ_STAT_IDX   = 8'h10;
   localparam logic [7:0] REG_IRQ_MASK_IDX   = 8'h11;
   localparam int         FLT_FRAME_BIT      = 0;
   localparam int         FLT_CS_BIT         = 1;
   localparam int         FLT_STARTUP_BIT    = 2;
   localparam int         PRI_SPI_FAULT_BIT  = 5;
   localparam int         HAM_POS            = 4;
   localparam int         WID_POS            = 2;
   localparam int         IFM_POS            = 0;
   localparam logic [7:0] SPI_FAULT_RST      = 8'h00;
   localparam logic [7:0] ERR_CNT_RST        = 8'h00;
   localparam logic [7:0] ERR_CNT_MAX        = 8'hFF;
   localparam logic [7:0] RSVD_RST           = 8'h00;
   localparam logic [7:0] ANA_CFG_RST        = 8'h60;
   localparam logic [2:0] IRQ_MASK_RST       = 3'h0;
   localparam int         IRQ_CS_BIT         = 0;
   localparam int         IRQ_FRAME_BIT      = 1;
   localparam int         IRQ_CNT_BIT        = 2;

   typedef struct packed {
      logic [1:0] hamming_pin_state;
      logic [1:0] word_width_pin_state;
      logic [1:0] interface_mode_pin_state;
   } sfr_mode_pins_t;

   typedef struct packed {
      logic startup_fault;
      logic cs_edge_sclk_high;
      logic frame_short;
      logic rx_word_error;
   } sfr_events_t;

   typedef struct packed {
      logic        sel;
      logic        write;
      logic [7:0]  idx;
   } sfr_addr_phase_t;
endpackage : sfr_pkg

/* src/sfr_sat_counter.sv */
// sfr_sat_counter: 8-bit saturating error tally with clear-on-read
// assumes: clr and inc are single-cycle pulses in the core_clk domain
`timescale 1ns/1ns
module sfr_sat_counter
   import sfr_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       rst_n,
   input  wire logic       inc,
   input  wire logic       clr,
   output logic [7:0]      count_q,
   output logic            sat_q
);
   // an error in the clearing cycle counts as one, so it is not lost
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         count_q <= ERR_CNT_RST;
      end else if (clr) begin
         count_q <= inc ? 8'h01 : ERR_CNT_RST;
      end else if (inc && count_q != ERR_CNT_MAX) begin
         count_q <= count_q + 8'h01;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         sat_q <= 1'b0;
      end else begin
         sat_q <= (count_q == ERR_CNT_MAX);
      end
   end
endmodule : sfr_sat_counter

/* dv/sfr_regs_asserts.sv */
// checker: port-level relations of the fault status bank
// assumes: bound to sfr_regs, mode pins steady once captured
`timescale 1ns/1ns
module sfr_regs_asserts
   import sfr_pkg::*;
(
   input wire logic                    core_clk,
   input wire logic                    rst_n,
   input wire logic                    hsel,
   input wire logic [31:0]             haddr,
   input wire logic [1:0]              htrans,
   input wire logic                    hwrite,
   input wire logic [31:0]             hwdata,
   input wire logic                    hready,
   input wire logic [31:0]             hrdata,
   input wire sfr_pkg::sfr_events_t    events,
   input wire sfr_pkg::sfr_mode_pins_t mode_pins,
   input wire logic [7:0]              analog_system_config
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   logic tk;
   logic st_q;
   assign tk = hsel && hready && htrans[1];
   // power-up fault seen since the last reset
   always_ff @(posedge core_clk) begin
      if (!rst_n) st_q <= 1'b0;
      else if (events.startup_fault) st_q <= 1'b1;
   end
   fault_rsvd_a: assert property (tk && !hwrite && haddr == 32'h14 |=> hrdata[31:3] == '0)
      else $error("fault register upper bits set");
   start_keep_a: assert property (tk && !hwrite && haddr == 32'h14 && st_q |=> hrdata[2])
      else $error("startup flag lost");
   cnt_rsvd_a: assert property (tk && !hwrite && haddr == 32'h18 |=> hrdata[31:8] == '0)
      else $error("counter upper bits set");
   mode_val_a: assert property (tk && !hwrite && haddr == 32'h1C |=> hrdata == {26'h0, $past(mode_pins)})
      else $error("mode pin capture wrong");
   rsvd_zero_a: assert property (tk && !hwrite && haddr inside {32'h20, 32'h24, 32'h28} |=> hrdata == '0)
      else $error("reserved slot not zero");
   cfg_write_a: assert property (tk && hwrite && haddr == 32'h2C |=> ##1 analog_system_config == $past(hwdata[7:0]))
      else $error("config write not applied");
   cfg_reset_a: assert property (disable iff (1'b0) !rst_n |=> analog_system_config == ANA_CFG_RST)
      else $error("config reset value wrong");
   prim_bits_a: assert property (tk && !hwrite && haddr == 32'h04 |=> hrdata[31:6] == '0 && hrdata[4:0] == '0)
      else $error("primary status stray bits");
   cover property (tk && !hwrite && haddr == 32'h14 && st_q);
   cover property (events.rx_word_error [*4]);
   cover property (tk && hwrite && haddr == 32'h2C);
endmodule : sfr_regs_asserts

/* dv/sfr_evt_src.sv */
// sfr_evt_src: stand-in for the serial interface logic raising fault events
// assumes: req changes just after a rising edge
`timescale 1ns/1ns
module sfr_evt_src
   import sfr_pkg::*;
(
   input  wire logic                 core_clk,
   input  wire logic                 rst_n,
   input  wire sfr_pkg::sfr_events_t req,
   output sfr_pkg::sfr_events_t      events
);
   // registered so each event is a clean clock-wide level
   always_ff @(posedge core_clk) begin
      if (!rst_n) events <= '0;
      else events <= req;
   end
endmodule : sfr_evt_src

/* dv/tb_top.sv */
// tb_top: self-checking bench for the fault status bank
// assumes: single AHB-Lite slave, hready fed from hreadyout
`timescale 1ns/1ns
module tb_top;
   import sfr_pkg::*;
   logic           core_clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, dp = 1'b0;
   logic [31:0]    haddr = '0, hwdata = '0, hrdata, v;
   logic [1:0]     htrans = '0;
   logic [2:0]     hsize = 3'h2;
   logic           hreadyout, hresp, irq;
   logic [7:0]     cfg;
   sfr_events_t    req = '0, events;
   sfr_mode_pins_t mode_pins = '0;
   logic [31:0]    exq[$];
   int             fails = 0, num_checks = 0, seed = 49101, n;
   always #10 core_clk = ~core_clk;
   sfr_evt_src sfr_evt_src_inst (.core_clk(core_clk), .rst_n(rst_n), .req(req), .events(events));
   sfr_regs sfr_regs_inst (.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .events(events), .mode_pins(mode_pins),
      .analog_system_config(cfg), .irq(irq));
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic xfer(input logic [7:0] idx, input logic w, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {22'h0, idx, 2'h0};
      hwrite <= w;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      if (w) hwdata <= d;
      dp <= !w;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      dp <= 1'b0;
   endtask : xfer
   task automatic rd(input logic [7:0] idx, input logic [31:0] e);
      exq.push_back(e);
      xfer(idx, 1'b0, '0);
   endtask : rd
   task automatic ev(input sfr_events_t e, input int c);
      req <= e;
      repeat (c) @(posedge core_clk);
      req <= '0;
      repeat (4) @(posedge core_clk);
   endtask : ev
   task automatic do_reset;
      rst_n <= 1'b0;
      repeat (6) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge core_clk);
   endtask : do_reset
   // read data are taken at the data-phase edge, oldest note first
   always @(posedge core_clk) begin
      if (dp && hreadyout === 1'b1) begin
         chk("hrdata", exq.pop_front(), hrdata);
         chk("hresp", 32'h0, {31'h0, hresp});
      end
   end
   initial begin
      mode_pins = 6'($random(seed));
      do_reset();
      rd(8'h05, 32'h0);
      rd(8'h06, 32'h0);
      rd(8'h07, {26'h0, mode_pins});
      for (int i = 8; i < 11; i++) rd(i[7:0], 32'h0);
      rd(8'h0B, 32'h60);
      rd(8'h3F, 32'h0);
      // read-only and reserved places must ignore writes
      for (int i = 5; i < 11; i++) xfer(i[7:0], 1'b1, 32'hFF);
      rd(8'h05, 32'h0);
      rd(8'h07, {26'h0, mode_pins});
      rd(8'h09, 32'h0);
      // fault held through the first read, so that read cannot clear it
      for (int b = 0; b < 2; b++) begin
         req <= b ? 4'h2 : 4'h4;
         repeat (3) @(posedge core_clk);
         rd(8'h01, 32'h20);
         rd(8'h05, b ? 32'h1 : 32'h2);
         req <= '0;
         repeat (6) @(posedge core_clk);
         rd(8'h05, b ? 32'h1 : 32'h2);
         rd(8'h05, 32'h0);
         rd(8'h01, 32'h0);
      end
      ev(4'h8, 1);
      rd(8'h05, 32'h4);
      rd(8'h05, 32'h4);
      n = 1 + {$random(seed)} % 20;
      ev(4'h1, n);
      rd(8'h06, 32'(n));
      rd(8'h06, 32'h0);
      ev(4'h1, 260);
      rd(8'h06, 32'hFF);
      v = $random(seed);
      xfer(8'h0B, 1'b1, v);
      rd(8'h0B, {24'h0, v[7:0]});
      chk("cfg", {24'h0, v[7:0]}, {24'h0, cfg});
      rd(8'h10, 32'h7);
      xfer(8'h11, 1'b1, 32'h7);
      ev(4'h4, 1);
      chk("irq", 32'h1, {31'h0, irq});
      rd(8'h10, 32'h1);
      repeat (3) @(posedge core_clk);
      chk("irq", 32'h0, {31'h0, irq});
      xfer(8'h11, 1'b1, 32'h0);
      ev(4'h2, 1);
      chk("irq", 32'h0, {31'h0, irq});
      rd(8'h10, 32'h2);
      do_reset();
      rd(8'h05, 32'h0);
      rd(8'h0B, 32'h60);
      tally_and_finish();
   end
   initial begin
      repeat (20000) @(posedge core_clk);
      fails++;
      tally_and_finish();
   end
endmodule : tb_top
bind sfr_regs sfr_regs_asserts sfr_regs_asserts_inst (.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
   .events(events), .mode_pins(mode_pins), .analog_system_config(analog_system_config));
